// ==== logic/clc_cell.sv ====
// programmable logic cell with lookup table, output register and apb configuration
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "clc_map.svh"

// How it works
// R01 - in normal mode four data inputs, with the carry-in able to stand in for one, address a 16-entry table.
// R02 - in normal mode a control bit picks either the carry-in or the third data input as table input.
// R03 - the table result is merged with the cascade-in to give the cascade-out for chaining wide functions.
// R04 - in normal mode the register may load the fourth data input while the table serves another function.
// R05 - in arithmetic mode the low eight table entries form a three-input function of carry-in and two data inputs.
// R06 - in arithmetic mode the high eight table entries give the carry-out from the same three signals.
// R07 - in arithmetic mode the cascade chain keeps working alongside the carry chain.
// R08 - in arithmetic mode both the registered and the unregistered function result are driven out; here comb_out is registered too, like reg_out.
// R09 - in counter mode the register has clock enable, count enable, up/down, synchronous clear and load.
// R10 - in counter mode count enable comes from the first data input and direction from the second.
// R11 - the cluster-wide synchronous clear and load act on the cell register in every mode.
// R12 - cells sharing a cluster with a counter are only part of that counter or purely combinational.
// R13 - four global control signals, each from a dedicated pin or from software, feed the register controls.
// R14 - clear beats load, load beats counting, and a low clock enable holds all three off.
module clc_cell (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_data_input,
  input wire logic second_data_input,
  input wire logic third_data_input,
  input wire logic fourth_data_input,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic cluster_sync_clear,
  input wire logic cluster_sync_load,
  input wire logic [3:0] global_pin,
  output logic comb_out,
  output logic reg_out,
  output logic carry_out,
  output logic cascade_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [1:0] addr_dec(input logic [11:0] a);
    // 0 ctrl, 1 lut, 2 glob, 3 status
    addr_dec = a[3:2];
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[11:4] == 8'h00) && (a[1:0] == 2'h0);
  endfunction

  // a source code of 0 means always on / never, 1..4 pick a global line
  function automatic logic src_pick(input clc_pkg::clc_src_t s, input logic [3:0] g,
                                    input logic dflt);
    case (s)
      3'h1: src_pick = g[0];
      3'h2: src_pick = g[1];
      3'h3: src_pick = g[2];
      3'h4: src_pick = g[3];
      default: src_pick = dflt;
    endcase
  endfunction

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [11:0] ctrl_r, ctrl_nxt;
  logic [15:0] lut_r, lut_nxt;
  logic [7:0] glob_r, glob_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic wr_go;
  logic [31:0] stat_word;

  // access phase always lasts exactly one cycle: pready rises the cycle after setup
  assign wr_go = psel && penable && pready && pwrite;

  always_comb begin
    ctrl_nxt = ctrl_r;
    lut_nxt = lut_r;
    glob_nxt = glob_r;
    prdata_nxt = prdata;
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !addr_ok(paddr);
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      if (!pwrite && addr_ok(paddr)) begin
        case (addr_dec(paddr))
          2'h0: prdata_nxt = {20'h00000, ctrl_r};
          2'h1: prdata_nxt = {16'h0000, lut_r};
          2'h2: prdata_nxt = {24'h000000, glob_r};
          default: prdata_nxt = stat_word;
        endcase
      end
    end
    if (wr_go && addr_ok(paddr)) begin
      case (addr_dec(paddr))
        2'h0: ctrl_nxt = pwdata[11:0];
        2'h1: lut_nxt = pwdata[15:0];
        2'h2: glob_nxt = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `CLC_CTRL_RST;
      lut_r <= `CLC_LUT_RST;
      glob_r <= `CLC_GLOB_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      lut_r <= lut_nxt;
      glob_r <= glob_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ****************************************************************
  // global control lines
  // ****************************************************************
  logic [3:0] glob_line;

  genvar gi;
  generate
    for (gi = 0; gi < `CLC_NUM_GLOBAL; gi = gi + 1) begin : g_glob
      // software may drive a line instead of its pin, e.g. an internal divider
      assign glob_line[gi] = glob_r[`CLC_GLOB_SRC_LSB + gi] ?
                             glob_r[`CLC_GLOB_VAL_LSB + gi] : global_pin[gi]; // [R13]
    end
  endgenerate

  // ****************************************************************
  // mode decode and table lookup
  // ****************************************************************
  clc_pkg::clc_mode_t mode;
  logic lut_in2;
  logic [3:0] idx4;
  logic [2:0] idx3;
  logic lut_out;
  logic sum_out;
  logic arith_carry;
  logic casc;
  logic ena;
  logic clr_g;

  always_comb begin
    case (ctrl_r[`CLC_CTRL_MODE_MSB:`CLC_CTRL_MODE_LSB])
      `CLC_MODE_ARITH: mode = clc_pkg::CLC_ARITH;
      `CLC_MODE_COUNT: mode = clc_pkg::CLC_COUNT;
      default: mode = clc_pkg::CLC_NORMAL;
    endcase
  end

  assign lut_in2 = ctrl_r[`CLC_CTRL_CARRY_SEL] ? carry_in : third_data_input; // [R02]
  assign idx4 = {fourth_data_input, lut_in2, second_data_input, first_data_input}; // [R01]
  assign lut_out = lut_r[idx4];
  assign idx3 = {carry_in, second_data_input, first_data_input};
  assign sum_out = lut_r[{1'b0, idx3}]; // [R05]
  assign arith_carry = lut_r[{1'b1, idx3}]; // [R06]

  // cascade merges whichever function the table produces in the current mode
  always_comb begin
    casc = (mode == clc_pkg::CLC_ARITH) ? sum_out : lut_out; // [R07]
    if (ctrl_r[`CLC_CTRL_CASC_EN]) begin
      casc = ctrl_r[`CLC_CTRL_CASC_OR] ? (casc | cascade_in) : (casc & cascade_in); // [R03]
    end
  end

  assign ena = src_pick(clc_pkg::clc_src_t'(ctrl_r[`CLC_CTRL_ENA_MSB:`CLC_CTRL_ENA_LSB]),
                        glob_line, 1'b1); // [R13]
  assign clr_g = src_pick(clc_pkg::clc_src_t'(ctrl_r[`CLC_CTRL_CLR_MSB:`CLC_CTRL_CLR_LSB]),
                          glob_line, 1'b0); // [R13]

  // ****************************************************************
  // cell register and outputs
  // ****************************************************************
  logic cell_nxt;
  logic comb_nxt;
  logic carry_nxt;
  logic cnt_toggle;

  // chaining outputs are registered, so each hop along a chain costs one cycle
  always_comb begin
    cnt_toggle = first_data_input & carry_in; // [R10]
    cell_nxt = reg_out;
    comb_nxt = lut_out;
    carry_nxt = 1'b0;
    case (mode)
      clc_pkg::CLC_NORMAL: begin
        comb_nxt = lut_out;
        carry_nxt = 1'b0;
        cell_nxt = ctrl_r[`CLC_CTRL_PACKED] ? fourth_data_input : lut_out; // [R04]
      end
      clc_pkg::CLC_ARITH: begin
        comb_nxt = sum_out; // [R08]
        carry_nxt = arith_carry; // [R06]
        cell_nxt = sum_out; // [R08]
      end
      clc_pkg::CLC_COUNT: begin
        cell_nxt = reg_out ^ cnt_toggle; // [R09]
        comb_nxt = reg_out ^ cnt_toggle;
        carry_nxt = carry_in & (second_data_input ? reg_out : ~reg_out); // [R10]
      end
      default: begin
        cell_nxt = reg_out;
        comb_nxt = lut_out;
        carry_nxt = 1'b0;
      end
    endcase
    if (cluster_sync_load) begin
      cell_nxt = fourth_data_input; // [R11] [R14]
    end
    if (cluster_sync_clear || clr_g) begin
      cell_nxt = 1'b0; // [R11] [R14]
    end
    if (!ena) begin
      cell_nxt = reg_out; // [R09] [R14]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_out <= 1'b0;
      comb_out <= 1'b0;
      carry_out <= 1'b0;
      cascade_out <= 1'b0;
    end else begin
      reg_out <= cell_nxt;
      comb_out <= comb_nxt;
      carry_out <= carry_nxt;
      cascade_out <= casc;
    end
  end

  // upper bits read as zero so software may mask the word freely
  assign stat_word = {24'h000000, glob_line, cascade_out, carry_out, comb_out, reg_out};

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_normal_lut: assert property ( // [R01]
    (mode == clc_pkg::CLC_NORMAL) |=> (comb_out == $past(lut_r[idx4])))
    else $error("normal mode output differs from table entry");

  chk_carry_select: assert property ( // [R02]
    (mode == clc_pkg::CLC_NORMAL && ctrl_r[`CLC_CTRL_CARRY_SEL])
    |=> (comb_out == $past(lut_r[{fourth_data_input, carry_in, second_data_input,
                                  first_data_input}])))
    else $error("carry select did not route carry-in");

  chk_cascade_and: assert property ( // [R03]
    (ctrl_r[`CLC_CTRL_CASC_EN] && !ctrl_r[`CLC_CTRL_CASC_OR] && !cascade_in)
    |=> !cascade_out)
    else $error("cascade and chain passed a one with cascade-in low");

  chk_packed_reg: assert property ( // [R04]
    (mode == clc_pkg::CLC_NORMAL && ctrl_r[`CLC_CTRL_PACKED] && ena
     && !cluster_sync_clear && !clr_g) |=> (reg_out == $past(fourth_data_input)))
    else $error("packed register did not take fourth input");

  chk_arith_sum: assert property ( // [R05]
    (mode == clc_pkg::CLC_ARITH) |=> (comb_out == $past(lut_r[{1'b0, idx3}])))
    else $error("arithmetic sum wrong");

  chk_arith_carry: assert property ( // [R06]
    (mode == clc_pkg::CLC_ARITH) |=> (carry_out == $past(lut_r[{1'b1, idx3}])))
    else $error("arithmetic carry wrong");

  chk_arith_both: assert property ( // [R08]
    (mode == clc_pkg::CLC_ARITH && ena && !cluster_sync_clear && !cluster_sync_load
     && !clr_g) |=> (reg_out == comb_out))
    else $error("registered and combinational arithmetic results differ");

  chk_count_step: assert property ( // [R10]
    (mode == clc_pkg::CLC_COUNT && ena && !cluster_sync_clear && !cluster_sync_load
     && !clr_g && first_data_input && carry_in) |=> (reg_out != $past(reg_out)))
    else $error("counter did not toggle");

  chk_clear_first: assert property ( // [R14]
    (ena && cluster_sync_clear && cluster_sync_load) |=> !reg_out)
    else $error("load won over clear");

  chk_ena_hold: assert property ( // [R09]
    (!ena) |=> $stable(reg_out))
    else $error("register changed with clock enable low");

  chk_global_sw: assert property ( // [R13]
    (glob_r[0] == 1'b1) |-> (glob_line[0] == glob_r[4]))
    else $error("software global line not used");

  chk_apb_ready: assert property (
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("apb answer not one cycle");

  // of the checks below only chk_arith_cascade indexes the table, from the pins, not through the index nets above
  chk_apb_error: assert property (
    (psel && !penable && paddr[11:4] != 8'h00) |=> (pready && pslverr))
    else $error("unmapped address not refused");

  chk_cascade_or: assert property ( // [R03]
    (ctrl_r[`CLC_CTRL_CASC_EN] && ctrl_r[`CLC_CTRL_CASC_OR] && cascade_in)
    |=> cascade_out)
    else $error("cascade or chain dropped a one from cascade-in");

  chk_arith_cascade: assert property ( // [R07]
    (mode == clc_pkg::CLC_ARITH && ctrl_r[`CLC_CTRL_CASC_EN] && !ctrl_r[`CLC_CTRL_CASC_OR])
    |=> (cascade_out == $past(lut_r[{1'b0, carry_in, second_data_input, first_data_input}]
                                & cascade_in)))
    else $error("cascade chain not merged with the arithmetic sum");

  chk_count_carry: assert property ( // [R10]
    (mode == clc_pkg::CLC_COUNT && !carry_in) |=> !carry_out)
    else $error("counter carry without carry-in");

  chk_load_take: assert property ( // [R11]
    (ena && cluster_sync_load && !cluster_sync_clear && !clr_g)
    |=> (reg_out == $past(fourth_data_input)))
    else $error("cluster load not taken");

  chk_global_clear: assert property ( // [R13]
    (ena && clr_g) |=> !reg_out)
    else $error("global clear line did not clear the register");

  cov_adder: cover property (mode == clc_pkg::CLC_ARITH && carry_out);
  cov_count: cover property (mode == clc_pkg::CLC_COUNT && cnt_toggle ##1 reg_out);
  cov_cascade: cover property (ctrl_r[`CLC_CTRL_CASC_EN] && cascade_out);
  cov_load: cover property (ena && cluster_sync_load ##1 reg_out);
  cov_glob_clear: cover property (ena && clr_g ##1 !reg_out);

endmodule // clc_cell

// ==== inc/clc_map.svh ====
// register offsets, field positions and reset values of the logic cell
`ifndef CLC_MAP_SVH
`define CLC_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CLC_OFS_CTRL 12'h000
`define CLC_OFS_LUT 12'h004
`define CLC_OFS_GLOB 12'h008
`define CLC_OFS_STAT 12'h00C

// ****************************************************************
// control register fields
// ****************************************************************
`define CLC_CTRL_MODE_LSB 0
`define CLC_CTRL_MODE_MSB 1
`define CLC_CTRL_CARRY_SEL 2
`define CLC_CTRL_CASC_EN 3
`define CLC_CTRL_PACKED 4
`define CLC_CTRL_CASC_OR 5
`define CLC_CTRL_ENA_LSB 6
`define CLC_CTRL_ENA_MSB 8
`define CLC_CTRL_CLR_LSB 9
`define CLC_CTRL_CLR_MSB 11
`define CLC_CTRL_WIDTH 12

// ****************************************************************
// global control register fields
// ****************************************************************
`define CLC_GLOB_SRC_LSB 0
`define CLC_GLOB_SRC_MSB 3
`define CLC_GLOB_VAL_LSB 4
`define CLC_GLOB_VAL_MSB 7
`define CLC_NUM_GLOBAL 4

// ****************************************************************
// mode codes in the control register
// ****************************************************************
`define CLC_MODE_NORMAL 2'h0
`define CLC_MODE_ARITH 2'h1
`define CLC_MODE_COUNT 2'h2

// ****************************************************************
// reset values
// ****************************************************************
`define CLC_CTRL_RST 12'h000
`define CLC_LUT_RST 16'h0000
`define CLC_GLOB_RST 8'h00

`endif

// ==== inc/clc_pkg.sv ====
// types shared by the logic cell design
package clc_pkg;

  typedef enum logic [1:0] {
    CLC_NORMAL,
    CLC_ARITH,
    CLC_COUNT
  } clc_mode_t;

  typedef logic [2:0] clc_src_t;

endpackage

// ==== sim/clc_nbr.sv ====
// upstream neighbour cell model feeding the carry and cascade chains
`timescale 1ns/1ps
module clc_nbr (
  input wire logic a,
  input wire logic b,
  output logic carry_in,
  output logic cascade_in
);
  // ****************************************************************
  // chain outputs
  // ****************************************************************
  // kept purely combinational, one of the two uses a cluster shared with a counter allows
  assign carry_in = a & b;
  assign cascade_in = a ^ b;
endmodule // clc_nbr

// ==== sim/clc_cell_tb.sv ====
// self-checking bench of the logic cell
`timescale 1ns/1ps
`include "clc_map.svh"
module clc_cell_tb;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr, ctrl;
  logic [31:0] pwdata, prdata, rd;
  logic d1, d2, d3, d4, pa, pb, carry_in, cascade_in, clr, ld, m_reg, valid;
  logic comb_out, reg_out, carry_out, cascade_out;
  logic [3:0] global_pin, ex, glob_src, glob_val;
  logic [15:0] lut;
  int mismatches = 0;
  int check_count = 0;
  clc_cell i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_data_input(d1), .second_data_input(d2), .third_data_input(d3),
    .fourth_data_input(d4), .carry_in(carry_in), .cascade_in(cascade_in),
    .cluster_sync_clear(clr), .cluster_sync_load(ld), .global_pin(global_pin),
    .comb_out(comb_out), .reg_out(reg_out), .carry_out(carry_out), .cascade_out(cascade_out));
  clc_nbr i_nbr (.a(pa), .b(pb), .carry_in(carry_in), .cascade_in(cascade_in));
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: register word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: cell output %b expected %b", $time, got, exp);
    end
  endtask
  // ****************************************************************
  // apb master
  // ****************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge mclk);
    penable <= 1'h1;
    // values read right at an edge are the ones that edge samples
    @(posedge mclk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) mismatches++;
  endtask
  // ****************************************************************
  // expectation
  // ****************************************************************
  function automatic logic [3:0] glines();
    return (glob_src & glob_val) | (~glob_src & global_pin);
  endfunction
  // returns {cascade, carry, register, table}; x where the output is not compared
  function automatic logic [3:0] model();
    logic [3:0] g;
    logic t, cy, en, cl, nr, cs;
    g = glines();
    t = lut[{d4, ctrl[2] ? carry_in : d3, d2, d1}];
    cy = 1'hx;
    if (ctrl[1:0] == `CLC_MODE_ARITH) begin
      t = lut[{1'h0, carry_in, d2, d1}];
      cy = lut[{1'h1, carry_in, d2, d1}];
    end
    nr = (ctrl[4] && ctrl[1:0] != `CLC_MODE_ARITH) ? d4 : t;
    if (ctrl[1:0] == `CLC_MODE_COUNT) begin
      nr = m_reg ^ (d1 & carry_in);
      cy = carry_in & (d2 ? m_reg : ~m_reg);
    end
    en = (ctrl[8:6] inside {[3'h1:3'h4]}) ? g[2'(ctrl[8:6] - 3'h1)] : 1'h1;
    cl = clr | ((ctrl[11:9] inside {[3'h1:3'h4]}) ? g[2'(ctrl[11:9] - 3'h1)] : 1'h0);
    if (cl) nr = 1'h0;
    else if (ld) nr = d4;
    if (!en) nr = m_reg;
    cs = ctrl[3] ? (ctrl[5] ? (t | cascade_in) : (t & cascade_in)) : t;
    if (ctrl[1:0] == `CLC_MODE_COUNT) return {cs, cy, nr, m_reg ^ (d1 & carry_in)};
    return {cs, cy, nr, t};
  endfunction
  // ****************************************************************
  // stimulus
  // ****************************************************************
  task automatic cfg(input logic [11:0] c, input logic [15:0] l, input logic [7:0] gl);
    valid = 1'h0;
    @(posedge mclk);
    // clear held with every line forced high, so the register starts from zero
    clr <= 1'h1;
    ld <= 1'h0;
    apb(1'h1, `CLC_OFS_GLOB, 32'h0000_00FF, rd, er);
    apb(1'h1, `CLC_OFS_CTRL, {20'h0, c}, rd, er);
    apb(1'h1, `CLC_OFS_LUT, {16'h0, l}, rd, er);
    apb(1'h1, `CLC_OFS_GLOB, {24'h0, gl}, rd, er);
    apb(1'h0, `CLC_OFS_CTRL, 32'h0, rd, er);
    cmp_word(rd, {20'h0, c});
    apb(1'h0, `CLC_OFS_LUT, 32'h0, rd, er);
    cmp_word(rd, {16'h0, l});
    ctrl = c;
    lut = l;
    {glob_val, glob_src} = gl;
    m_reg = 1'h0;
  endtask
  task automatic run(input int n);
    repeat (n) begin
      @(posedge mclk);
      {d1, d2, d3, d4, pa, pb} <= 6'($urandom);
      global_pin <= 4'($urandom);
      clr <= ($urandom % 8) == 0;
      ld <= ($urandom % 8) == 1;
      #1;
      if (valid) begin
        cmp_bit(reg_out, ex[1]);
        if (ex[0] !== 1'hx) cmp_bit(comb_out, ex[0]);
        if (ex[2] !== 1'hx) cmp_bit(carry_out, ex[2]);
        if (ex[3] !== 1'hx) cmp_bit(cascade_out, ex[3]);
      end
      ex = model();
      m_reg = ex[1];
      valid = 1'h1;
    end
  endtask
  initial begin
    {rstn, psel, penable, pwrite, clr, ld, d1, d2, d3, d4, pa, pb, valid, m_reg} = '0;
    {paddr, pwdata, global_pin, ctrl, lut, glob_src, glob_val, ex} = '0;
    void'($urandom(58));
    repeat (5) @(posedge mclk);
    rstn <= 1'h1;
    apb(1'h0, `CLC_OFS_GLOB, 32'h0, rd, er);
    cmp_word(rd, 32'h0);
    apb(1'h0, 12'h010, 32'h0, rd, er);
    cmp_word({31'h0, er}, 32'h1);
    for (int m = 0; m < 4; m++) begin
      repeat (5) begin
        cfg({10'($urandom), 2'(m)}, 16'($urandom), 8'($urandom));
        run(40);
        apb(1'h0, `CLC_OFS_STAT, 32'h0, rd, er);
        cmp_word({28'h0, rd[7:4]}, {28'h0, glines()});
      end
    end
    test_done();
  end
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule // clc_cell_tb
